// *** rtl/lpt_pkg.sv ***
// lpt_pkg: constants, register map and carrier structs for the printer port
// assumes: a 32-bit apb slave with word-aligned registers

package lpt_pkg;

   // ************************************************************
   // register byte offsets
   // ************************************************************
   localparam logic [7:0] OFF_DATA    = 8'h00;  // output byte, reads the register when driving, else the pins
   localparam logic [7:0] OFF_STATUS  = 8'h04;  // printer status inputs
   localparam logic [7:0] OFF_CONTROL = 8'h08;  // control bits
   localparam logic [7:0] OFF_IRQ_ST  = 8'h0C;  // sticky event status, read only
   localparam logic [7:0] OFF_IRQ_CLR = 8'h10;  // write one to clear
   localparam logic [7:0] OFF_IRQ_EN  = 8'h14;  // event enable

   // ************************************************************
   // control register fields
   // ************************************************************
   localparam int CTL_STROBE = 0;
   localparam int CTL_AUTOLF = 1;
   localparam int CTL_INIT   = 2;
   localparam int CTL_SELECT = 3;
   localparam int CTL_DIR_IN = 5;  // 1: data bus is input

   // ************************************************************
   // status register fields
   // ************************************************************
   localparam int STS_FAULT  = 3;  // level of the active-low fault input
   localparam int STS_ONLINE = 4;
   localparam int STS_PAPER  = 5;
   localparam int STS_ACK    = 6;
   localparam int STS_BUSY   = 7;

   // ************************************************************
   // event bits
   // ************************************************************
   localparam int EV_ACK   = 0;  // falling edge of acknowledge
   localparam int EV_FAULT = 1;  // fault asserted
   localparam int EV_PAPER = 2;  // paper ran out
   localparam int EV_W     = 3;

   // ************************************************************
   // reset values
   // ************************************************************
   localparam logic [7:0]      RST_DATA    = 8'h00;
   localparam logic [7:0]      RST_CONTROL = 8'h04;  // init pin high, idle
   localparam logic [EV_W-1:0] RST_EVENTS  = 3'h0;

   // printer status inputs
   typedef struct packed {
      logic busy;
      logic ack_n;
      logic paper_out;
      logic printer_online;
      logic fault_n;
   } prn_status_s;

   // printer control outputs
   typedef struct packed {
      logic data_strobe_n;
      logic auto_line_feed_n;
      logic init_n;
      logic select_printer_n;
   } prn_ctrl_s;

endpackage

// *** rtl/printer_port.sv ***
// printer_port: apb register block driving a byte-wide printer port
// assumes: apb master on ref_clk, printer inputs synchronous to ref_clk,
// the data pads resolved outside from byte_out / byte_oe
//
// Implementation choices: the register offsets and the APB slave port.

`timescale 1ns/10ps

module printer_port
   import lpt_pkg::*;
(
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        resetn,
   // apb slave
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   // printer pins
   output prn_ctrl_s        prn_ctrl,
   input  wire prn_status_s prn_status,
   input  wire logic [7:0]  byte_in,
   output logic      [7:0]  byte_out,
   output logic             byte_oe,
   // interrupt
   output logic             irq
);

   // ************************************************************
   // bus decode
   // ************************************************************
   logic             wr_req;
   logic             rd_req;
   logic             known;
   logic [7:0]       data_reg;
   logic [7:0]       ctl_reg;
   logic [EV_W-1:0]  ev_st;
   logic [EV_W-1:0]  ev_en;
   logic [7:0]       sts_word;
   logic [EV_W-1:0]  ev_hit;
   logic             ack_q;
   logic             fault_q;
   logic             paper_q;
   logic             hold_byte;

   function automatic logic is_mapped(input logic [7:0] a);
      return (a == OFF_DATA) || (a == OFF_STATUS) || (a == OFF_CONTROL) ||
             (a == OFF_IRQ_ST) || (a == OFF_IRQ_CLR) || (a == OFF_IRQ_EN);
   endfunction

   // one-cycle access phase, answered in the setup-following cycle
   assign wr_req = psel && penable && pwrite && pready;
   assign rd_req = psel && !penable && !pwrite;
   assign known  = is_mapped(paddr);

   // status word seen by software
   always_comb begin
      sts_word             = 8'h00;
      sts_word[STS_FAULT]  = prn_status.fault_n;
      sts_word[STS_ONLINE] = prn_status.printer_online;
      sts_word[STS_PAPER]  = prn_status.paper_out;
      sts_word[STS_ACK]    = prn_status.ack_n;
      sts_word[STS_BUSY]   = prn_status.busy;
   end

   // pready high in the access phase, zero wait states
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && !is_mapped(paddr);
      end
   end

   // read data registered in the setup cycle
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         prdata <= 32'h0000_0000;
      end else if (rd_req) begin
         case (paddr)
            OFF_DATA:    prdata <= {24'h00_0000, byte_oe ? data_reg : byte_in};
            OFF_STATUS:  prdata <= {24'h00_0000, sts_word};
            OFF_CONTROL: prdata <= {24'h00_0000, ctl_reg};
            OFF_IRQ_ST:  prdata <= {29'h0000_0000, ev_st};
            OFF_IRQ_EN:  prdata <= {29'h0000_0000, ev_en};
            default:     prdata <= 32'h0000_0000;
         endcase
      end
   end

   // ************************************************************
   // data and control registers
   // ************************************************************
   // byte held while strobe low or acknowledge pending
   assign hold_byte = ctl_reg[CTL_STROBE] || !prn_status.ack_n;

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         data_reg <= RST_DATA;
      end else if (wr_req && known && paddr == OFF_DATA && !hold_byte) begin
         data_reg <= pwdata[7:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         ctl_reg <= RST_CONTROL;
      end else if (wr_req && paddr == OFF_CONTROL) begin
         ctl_reg <= pwdata[7:0] & 8'h2F;
      end
   end

   // ************************************************************
   // pin drive
   // ************************************************************
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         prn_ctrl <= '{data_strobe_n: 1'b1, auto_line_feed_n: 1'b1,
                        init_n: 1'b1, select_printer_n: 1'b1};
         byte_out <= 8'h00;
         byte_oe  <= 1'b0;
      end else begin
         prn_ctrl.data_strobe_n    <= !ctl_reg[CTL_STROBE];
         // auto feed inverse of bit 1
         prn_ctrl.auto_line_feed_n <= !ctl_reg[CTL_AUTOLF];
         prn_ctrl.init_n           <= ctl_reg[CTL_INIT];
         prn_ctrl.select_printer_n <= !ctl_reg[CTL_SELECT];
         byte_out                  <= data_reg;
         // release the bus unless selected and output
         byte_oe <= ctl_reg[CTL_SELECT] && !ctl_reg[CTL_DIR_IN];
      end
   end

   // ************************************************************
   // events and interrupt
   // ************************************************************
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         ack_q   <= 1'b1;
         fault_q <= 1'b1;
         paper_q <= 1'b0;
      end else begin
         ack_q   <= prn_status.ack_n;
         fault_q <= prn_status.fault_n;
         paper_q <= prn_status.paper_out;
      end
   end

   always_comb begin
      ev_hit           = '0;
      ev_hit[EV_ACK]   = ack_q && !prn_status.ack_n;
      ev_hit[EV_FAULT] = fault_q && !prn_status.fault_n;
      ev_hit[EV_PAPER] = !paper_q && prn_status.paper_out;
   end

   // set beats clear
   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         ev_st <= RST_EVENTS;
      end else if (wr_req && paddr == OFF_IRQ_CLR) begin
         ev_st <= (ev_st & ~pwdata[EV_W-1:0]) | ev_hit;
      end else begin
         ev_st <= ev_st | ev_hit;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         ev_en <= RST_EVENTS;
      end else if (wr_req && paddr == OFF_IRQ_EN) begin
         ev_en <= pwdata[EV_W-1:0];
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!resetn) begin
         irq <= 1'b0;
      end else begin
         irq <= |((ev_st | ev_hit) & ev_en);
      end
   end

   // ************************************************************
   // checks
   // ************************************************************
   property p_strobe;
      @(posedge ref_clk) disable iff (!resetn)
      ##1 prn_ctrl.data_strobe_n == !$past(ctl_reg[CTL_STROBE]);
   endproperty
   a_strobe: assert property (p_strobe) else $error("strobe not inverse of bit 0");

   property p_autolf;
      @(posedge ref_clk) disable iff (!resetn)
      $rose(ctl_reg[CTL_AUTOLF]) |=> !prn_ctrl.auto_line_feed_n;
   endproperty
   a_autolf: assert property (p_autolf) else $error("auto feed not low");

   property p_init;
      @(posedge ref_clk) disable iff (!resetn)
      $fell(ctl_reg[CTL_INIT]) |=> !prn_ctrl.init_n;
   endproperty
   a_init: assert property (p_init) else $error("init not following bit 2");

   property p_select;
      @(posedge ref_clk) disable iff (!resetn)
      ctl_reg[CTL_SELECT] |=> !prn_ctrl.select_printer_n;
   endproperty
   a_select: assert property (p_select) else $error("select not low");

   property p_fault;
      @(posedge ref_clk) disable iff (!resetn)
      rd_req && paddr == OFF_STATUS |=> prdata[STS_FAULT] == $past(prn_status.fault_n);
   endproperty
   a_fault: assert property (p_fault) else $error("fault bit wrong");

   property p_float;
      @(posedge ref_clk) disable iff (!resetn)
      !ctl_reg[CTL_SELECT] |=> !byte_oe;
   endproperty
   a_float: assert property (p_float) else $error("bus driven when unselected");

   property p_hold;
      @(posedge ref_clk) disable iff (!resetn)
      hold_byte |=> $stable(data_reg);
   endproperty
   a_hold: assert property (p_hold) else $error("byte changed while held");

   property p_irq;
      @(posedge ref_clk) disable iff (!resetn)
      (ev_st[EV_ACK] && ev_en[EV_ACK]) |=> irq;
   endproperty
   a_irq: assert property (p_irq) else $error("interrupt missing");

endmodule

// *** verif/printer_model.sv ***
// printer_model: behavioural line printer on the far side of the port
// assumes: pins sampled on ref_clk, knobs driven by the bench
`timescale 1ns/10ps
module printer_model
   import lpt_pkg::*;
(
   // clock and reset
   input  wire logic       ref_clk,
   input  wire logic       resetn,
   // pins and bench knobs
   input  wire prn_ctrl_s  ctrl,
   input  wire logic [7:0] pads,
   input  wire logic       fault_in,
   input  wire logic       paper_in,
   output prn_status_s     status,
   output logic      [7:0] latched,
   output logic      [7:0] feeds
);
   logic       strobe_q;
   logic       online;
   logic [2:0] cnt;
   // ************************************************************
   // handshake
   // ************************************************************
   // busy then ack pulse, paper and online levels
   // one driver for the whole status struct
   assign status = {cnt > 3'h2,                     // busy
                    !(cnt == 3'h1 || cnt == 3'h2),  // ack_n
                    paper_in,
                    online,
                    fault_in};
   always @(posedge ref_clk) begin
      strobe_q <= ctrl.data_strobe_n;
      online <= !ctrl.select_printer_n;
      if (!resetn) begin
         cnt <= 3'h0;
         feeds <= 8'h00;
         latched <= 8'h00;
      end else if (strobe_q && !ctrl.data_strobe_n) begin
         latched <= pads;
         cnt <= 3'h6;
      end else if (cnt != 3'h0) begin
         cnt <= cnt - 3'h1;
         if (cnt == 3'h1 && !ctrl.auto_line_feed_n) feeds <= feeds + 8'h01;
      end
   end
endmodule

// *** verif/testbench.sv ***
// testbench: apb-driven checks of the printer port with a printer model
// assumes: lpt_pkg, printer_port and printer_model compiled first
`timescale 1ns/10ps
module testbench import lpt_pkg::*;;
   logic        ref_clk = 1'b0;
   logic        resetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic        fault_in = 1'b1;
   logic        paper_in = 1'b0;
   logic [7:0]  paddr = 8'h00;
   logic [7:0]  back = 8'h3C;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready, pslverr, byte_oe, irq;
   logic [7:0]  byte_out, byte_in, latched;
   logic [7:0]  feeds, feed_base;
   prn_ctrl_s   prn_ctrl;
   prn_status_s prn_status;
   logic [32:0] exp_q[$];
   logic [15:0] lf = 16'h0A55;
   int          err_count = 0;
   int          compares = 0;
   // pads: port drives when enabled, else printer data
   assign byte_in = byte_oe ? byte_out : back;
   always #5 ref_clk = ~ref_clk;
   printer_port i_dut (.ref_clk(ref_clk), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .prn_ctrl(prn_ctrl),
      .prn_status(prn_status), .byte_in(byte_in), .byte_out(byte_out),
      .byte_oe(byte_oe), .irq(irq));
   printer_model i_prn (.ref_clk(ref_clk), .resetn(resetn), .ctrl(prn_ctrl),
      .pads(byte_in), .fault_in(fault_in), .paper_in(paper_in),
      .status(prn_status), .latched(latched), .feeds(feeds));
   // ************************************************************
   // helpers
   // ************************************************************
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   task automatic check(input logic [32:0] got, input logic [32:0] e);
      compares++;
      if (got !== e) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      do @(posedge ref_clk); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [7:0] a, input logic [32:0] e);
      exp_q.push_back(e);
      apb(1'b0, a, 32'h0);
   endtask
   task final_report;
      $display("compares %0d mismatches %0d", compares, err_count);
      if (err_count == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   // read monitor: oldest note against each completed read
   always @(posedge ref_clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite)
         check({pslverr, prdata}, exp_q.pop_front());
   end
   initial begin
      #100000;
      err_count++;
      final_report();
   end
   // ************************************************************
   // scenarios
   // ************************************************************
   initial begin
      repeat (10) @(posedge ref_clk);
      resetn <= 1'b1;
      @(posedge ref_clk);
      check(33'({prn_ctrl, byte_oe, irq}), 33'h3C);
      rd(OFF_CONTROL, 33'(RST_CONTROL));
      rd(OFF_DATA, 33'(back));
      rd(8'h20, 33'h1_0000_0000);
      $display("test reset done");
      for (int i = 0; i < 8; i++) begin
         lf = lfsr(lf);
         apb(1'b1, OFF_CONTROL, {28'h0, lf[3:0]});
         @(posedge ref_clk);
         check(33'({prn_ctrl, byte_oe}), 33'({~lf[0], ~lf[1], lf[2], ~lf[3], lf[3]}));
      end
      apb(1'b1, OFF_CONTROL, 32'h04);
      repeat (10) @(posedge ref_clk);
      $display("test pins done");
      apb(1'b1, OFF_IRQ_CLR, 32'h7);
      apb(1'b1, OFF_IRQ_EN, 32'h1);
      lf = lfsr(lf);
      apb(1'b1, OFF_DATA, {24'h0, lf[7:0]});
      feed_base = feeds;
      apb(1'b1, OFF_CONTROL, 32'h0F);
      apb(1'b1, OFF_DATA, {24'h0, ~lf[7:0]});
      rd(OFF_STATUS, 33'hD8);
      rd(OFF_DATA, 33'(lf[7:0]));
      check(33'(latched), 33'(lf[7:0]));
      apb(1'b1, OFF_CONTROL, 32'h0C);
      for (int i = 0; i < 40 && irq !== 1'b1; i++) @(posedge ref_clk);
      check(33'(irq), 33'h1);
      rd(OFF_IRQ_ST, 33'h1);
      check(33'(feeds), 33'(feed_base + 8'h01));
      apb(1'b1, OFF_IRQ_CLR, 32'h1);
      @(posedge ref_clk);
      check(33'(irq), 33'h0);
      $display("test strobe done");
      apb(1'b1, OFF_IRQ_EN, 32'h0);
      fault_in <= 1'b0;
      paper_in <= 1'b1;
      repeat (4) @(posedge ref_clk);
      check(33'(irq), 33'h0);
      rd(OFF_IRQ_ST, 33'h6);
      rd(OFF_STATUS, 33'h70);
      fault_in <= 1'b1;
      repeat (4) @(posedge ref_clk);
      rd(OFF_STATUS, 33'h78);
      apb(1'b1, OFF_CONTROL, 32'h2C);
      @(posedge ref_clk);
      check(33'(byte_oe), 33'h0);
      rd(OFF_DATA, 33'(back));
      $display("test status done");
      final_report();
   end
endmodule
